// ### src/ohm_port.sv
// Purpose: Overhead serial port sharing its pins with the packet byte port.
// Assumes: ref_clk 20 MHz; overhead clocks and pin inputs are asynchronous.
// Notes:   One channel; instantiate once per channel.
// Notes on behaviour
// [R1] Pin function follows per-channel packet mode
// [R2] Received overhead bits shift out on clock rise
// [R3] Packet mode: output carries receive byte bit 6
// [R4] Frame pulse marks first overhead bit expected
// [R5] Frame pulse lasts one transmit clock period
// [R6] Packet mode: pulse pin is byte demand/latch clock
// [R7] Insert high: sample input on falling clock edge
// [R8] Non-insertable bit: ignore insert, keep own value
// [R9] Mode change applies from next overhead clock cycle; code switches on the next ref_clk cycle, with no staging
`timescale 1ns/1ps
`default_nettype none

`include "ohm_defs.svh"

// ----------------------------------------------------------------------
// Simple synchronous FIFO
// ----------------------------------------------------------------------
module ohm_fifo
    import ohm_pkg::*;
#(
    parameter int WIDTH = `OHM_FIFO_WIDTH,
    parameter int DEPTH = `OHM_FIFO_DEPTH
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage array
    logic [AW-1:0]    wr_q, wr_d;      // Write pointer
    logic [AW-1:0]    rd_q, rd_d;      // Read pointer
    logic [AW:0]      cnt_q, cnt_d;    // Fill level
    logic             push;            // Word accepted
    logic             pop;             // Word drained

    // Level is one bit wider than the pointers so that full reads as DEPTH, not zero
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and level update
    always_comb
    begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointer registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; contents only matter once counted in
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Pin mux top
// ----------------------------------------------------------------------
module ohm_port
    import ohm_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   packet_mode,
    input  wire logic                   rx_oh_valid,
    output logic                        rx_oh_ready,
    input  wire logic                   rx_oh_bit,
    input  wire logic [`OHM_BYTE_W-1:0] rx_packet_byte_bus,
    input  wire logic                   tx_first_oh_req,
    input  wire logic                   tx_bit_insertable,
    input  wire logic                   rx_overhead_clock,
    input  wire logic                   tx_overhead_clock,
    input  wire logic                   tx_overhead_in,
    input  wire logic                   tx_overhead_insert,
    input  wire logic [`OHM_BYTE_W-1:0] tx_packet_byte_bus,
    output logic                        rx_overhead_out,
    output logic                        tx_overhead_frame_pulse,
    output ohm_tx_bit_t                 tx_oh_bit,
    output ohm_tx_byte_t                tx_byte
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    ohm_pins_t      pins_raw;        // Pin levels as they arrive
    ohm_pins_t      meta_q;          // First stage, read only by sync_q
    ohm_pins_t      sync_q;          // Second stage, safe to use
    ohm_pins_t      prev_q;          // Previous synced levels for edges
    logic           rx_rise;         // Receive overhead clock rose
    logic           tx_rise;         // Transmit overhead clock rose
    logic           tx_fall;         // Transmit overhead clock fell

    assign pins_raw = '{rx_clk: rx_overhead_clock, tx_clk: tx_overhead_clock,
                        tx_in: tx_overhead_in, tx_ins: tx_overhead_insert,
                        tx_byte: tx_packet_byte_bus};

    // Two flops plus an edge history stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= pins_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rx_rise = sync_q.rx_clk && !prev_q.rx_clk;
    assign tx_rise = sync_q.tx_clk && !prev_q.tx_clk;
    assign tx_fall = !sync_q.tx_clk && prev_q.tx_clk;

    // ------------------------------------------------------------------
    // Receive overhead bit buffer
    // ------------------------------------------------------------------
    logic buf_valid;                 // Bit waiting for the pin
    logic buf_bit;                   // Oldest buffered bit
    logic buf_pop;                   // Drain one bit on clock rise

    // Only drains while the pin serves overhead, so the buffer
    // really fills and stalls the receive section in packet mode
    assign buf_pop = rx_rise && !packet_mode; // [R2]

    ohm_fifo #(
        .WIDTH (`OHM_FIFO_WIDTH),
        .DEPTH (`OHM_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (rx_oh_valid),
        .in_ready  (rx_oh_ready),
        .in_data   (rx_oh_bit),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_bit)
    );

    // ------------------------------------------------------------------
    // Receive pin function
    // ------------------------------------------------------------------
    logic rx_pin_q, rx_pin_d;        // Receive overhead output pin

    // Mode picks the source directly; no staging of the mode bit
    always_comb
    begin
        rx_pin_d = rx_pin_q;
        if (packet_mode) // [R1] [R9]
        begin
            rx_pin_d = rx_packet_byte_bus[`OHM_RX_PKT_BIT]; // [R3]
        end
        else if (buf_pop && buf_valid)
        begin
            rx_pin_d = buf_bit; // [R2]
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_pin_q <= `OHM_PIN_RST;
        end
        else
        begin
            rx_pin_q <= rx_pin_d;
        end
    end

    assign rx_overhead_out = rx_pin_q;

    // ------------------------------------------------------------------
    // Frame pulse sequencer and shared transmit pin
    // ------------------------------------------------------------------
    ohm_fp_state_t fp_q, fp_d;       // Frame pulse state
    logic          fp_pin_q, fp_pin_d; // Shared transmit pin

    // Request arms; next clock rise raises; following rise lowers
    always_comb
    begin
        fp_d = fp_q;
        unique case (fp_q)
            OHM_FP_IDLE:
            begin
                if (tx_first_oh_req && !packet_mode)
                begin
                    fp_d = OHM_FP_ARMED;
                end
            end
            OHM_FP_ARMED:
            begin
                if (packet_mode)
                begin
                    fp_d = OHM_FP_IDLE;
                end
                else if (tx_rise)
                begin
                    fp_d = OHM_FP_HIGH; // [R4]
                end
            end
            OHM_FP_HIGH:
            begin
                // Exactly one transmit clock period high
                if (packet_mode)
                begin
                    fp_d = OHM_FP_IDLE;
                end
                else if (tx_rise)
                begin
                    fp_d = tx_first_oh_req ? OHM_FP_ARMED : OHM_FP_IDLE; // [R5]
                end
            end
            default:
            begin
                fp_d = OHM_FP_IDLE;
            end
        endcase
        // Packet mode: pin follows the clock as byte demand/latch
        if (packet_mode) // [R1] [R9]
        begin
            fp_pin_d = sync_q.tx_clk; // [R6]
        end
        else
        begin
            fp_pin_d = (fp_d == OHM_FP_HIGH); // [R4] [R5]
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fp_q     <= OHM_FP_IDLE;
            fp_pin_q <= `OHM_PIN_RST;
        end
        else
        begin
            fp_q     <= fp_d;
            fp_pin_q <= fp_pin_d;
        end
    end

    assign tx_overhead_frame_pulse = fp_pin_q;

    // ------------------------------------------------------------------
    // Transmit insertion and byte latch
    // ------------------------------------------------------------------
    ohm_tx_bit_t  txb_q, txb_d;      // Overhead bit to the framer
    ohm_tx_byte_t txy_q, txy_d;      // Packet byte to the controller

    // Both act on the falling clock edge, one pulse per edge
    always_comb
    begin
        txb_d = '{valid: 1'b0, bit_val: txb_q.bit_val, external: 1'b0};
        txy_d = '{valid: 1'b0, data: txy_q.data};
        if (tx_fall && !packet_mode)
        begin
            txb_d.valid = 1'b1;
            if (sync_q.tx_ins && tx_bit_insertable) // [R7] [R8]
            begin
                txb_d.bit_val  = sync_q.tx_in; // [R7]
                txb_d.external = 1'b1;
            end
        end
        if (tx_fall && packet_mode)
        begin
            // Byte latched half a period after demand, settled by then
            txy_d.valid = 1'b1; // [R6]
            txy_d.data  = sync_q.tx_byte;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            txb_q <= '0;
            txy_q <= '{valid: 1'b0, data: `OHM_BYTE_RST};
        end
        else
        begin
            txb_q <= txb_d;
            txy_q <= txy_d;
        end
    end

    assign tx_oh_bit = txb_q;
    assign tx_byte   = txy_q;
endmodule

`default_nettype wire

// ### src/ohm_defs.svh
// Purpose: Constants of the overhead port / packet byte port pin mux.
// Assumes: Included by its bare name wherever the constants are needed.
// Notes:   Definitions only.
`ifndef OHM_DEFS_SVH
`define OHM_DEFS_SVH

// ----------------------------------------------------------------------
// Buffer shape
// ----------------------------------------------------------------------
`define OHM_FIFO_DEPTH      16
`define OHM_FIFO_WIDTH      1

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define OHM_BYTE_W          8
`define OHM_RX_PKT_BIT      6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OHM_PIN_RST         1'h0
`define OHM_BYTE_RST        8'h00

`endif

// ### src/ohm_pkg.sv
// Purpose: Types shared by the overhead port pin mux.
// Assumes: ohm_defs.svh gives the widths.
// Notes:   Types only; numbers live in the header.
`include "ohm_defs.svh"

package ohm_pkg;

    // ------------------------------------------------------------------
    // Frame pulse sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OHM_FP_IDLE  = 3'h1,
        OHM_FP_ARMED = 3'h2,
        OHM_FP_HIGH  = 3'h4
    } ohm_fp_state_t;

    // ------------------------------------------------------------------
    // Synchronised pin levels from the far side
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic                   rx_clk;
        logic                   tx_clk;
        logic                   tx_in;
        logic                   tx_ins;
        logic [`OHM_BYTE_W-1:0] tx_byte;
    } ohm_pins_t;

    // ------------------------------------------------------------------
    // Transmit overhead bit handed to the transmit framer
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic valid;
        logic bit_val;
        logic external;
    } ohm_tx_bit_t;

    // ------------------------------------------------------------------
    // Transmit packet byte handed to the packet controller
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic                   valid;
        logic [`OHM_BYTE_W-1:0] data;
    } ohm_tx_byte_t;

endpackage

// ### testbench/ohm_port_properties.sv
// Purpose: Port-level properties of the overhead / packet byte pin mux.
// Assumes: Pins are seen through the same two-flop sampling as the block.
// Notes:   Bound to ohm_port from the testbench top.
`timescale 1ns/1ps
`default_nettype none
`include "ohm_defs.svh"
module ohm_port_props
    import ohm_pkg::*;
(
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   packet_mode,
    input wire logic [`OHM_BYTE_W-1:0] rx_packet_byte_bus,
    input wire logic                   tx_first_oh_req,
    input wire logic                   tx_bit_insertable,
    input wire logic                   rx_overhead_clock,
    input wire logic                   tx_overhead_clock,
    input wire logic                   tx_overhead_in,
    input wire logic                   tx_overhead_insert,
    input wire logic [`OHM_BYTE_W-1:0] tx_packet_byte_bus,
    input wire logic                   rx_overhead_out,
    input wire logic                   tx_overhead_frame_pulse,
    input wire ohm_tx_bit_t            tx_oh_bit,
    input wire ohm_tx_byte_t           tx_byte
);
    // ------------------------------------------------------------------
    // Pin sampling mirror
    // ------------------------------------------------------------------
    logic [2:0]             rc_q;   // Receive clock pin history
    logic [2:0]             tc_q;   // Transmit clock pin history
    logic [1:0]             ti_q;   // Insert pin history
    logic [1:0]             td_q;   // Overhead data pin history
    logic [`OHM_BYTE_W-1:0] b1_q;   // Byte bus, first stage
    logic [`OHM_BYTE_W-1:0] b2_q;   // Byte bus, second stage
    logic [1:0]             up_q;   // Edges since reset, saturating
    logic                   pm_q;   // Mode one edge ago
    logic                   rxr;    // Receive clock rise seen
    logic                   txr;    // Transmit clock rise seen
    logic                   txf;    // Transmit clock fall seen
    logic                   up;     // Past values are trustworthy
    // Same depth as the block, so detected edges line up cycle for cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {rc_q, tc_q, ti_q, td_q, b1_q, b2_q, up_q, pm_q} <= '0;
        end
        else
        begin
            rc_q <= {rc_q[1:0], rx_overhead_clock};
            tc_q <= {tc_q[1:0], tx_overhead_clock};
            ti_q <= {ti_q[0], tx_overhead_insert};
            td_q <= {td_q[0], tx_overhead_in};
            b1_q <= tx_packet_byte_bus;
            b2_q <= b1_q;
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
            pm_q <= packet_mode;
        end
    end
    assign rxr = rc_q[1] & ~rc_q[2];
    assign txr = tc_q[1] & ~tc_q[2];
    assign txf = ~tc_q[1] & tc_q[2];
    assign up  = (up_q == 2'h3);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_rx_bit_six: assert property (@(posedge ref_clk) disable iff (rst)
        up && packet_mode |=> rx_overhead_out == $past(rx_packet_byte_bus[6]))
        else $error("receive pin does not follow byte bit 6");
    a_rx_hold_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        up && !packet_mode && !pm_q && !rxr |=> $stable(rx_overhead_out))
        else $error("receive pin moved without a clock rise");
    a_pulse_on_rise: assert property (@(posedge ref_clk) disable iff (rst)
        up && !pm_q && $rose(tx_overhead_frame_pulse) |-> $past(txr))
        else $error("frame pulse rose without a clock rise");
    a_pulse_hold: assert property (@(posedge ref_clk) disable iff (rst)
        up && !packet_mode && !pm_q && !txr |=> $stable(tx_overhead_frame_pulse))
        else $error("frame pulse moved between clock rises");
    a_pulse_close: assert property (@(posedge ref_clk) disable iff (rst)
        up && !packet_mode && !pm_q && tx_overhead_frame_pulse && txr && !tx_first_oh_req
        |=> !tx_overhead_frame_pulse)
        else $error("frame pulse outlived one clock period");
    a_pkt_clk_mirror: assert property (@(posedge ref_clk) disable iff (rst)
        up && packet_mode && pm_q |=> tx_overhead_frame_pulse == $past(tc_q[1]))
        else $error("byte clock does not mirror the transmit clock");
    a_pkt_byte_latch: assert property (@(posedge ref_clk) disable iff (rst)
        up && packet_mode && txf |=> tx_byte.valid && tx_byte.data == $past(b2_q))
        else $error("byte not latched on the clock fall");
    a_pkt_byte_only: assert property (@(posedge ref_clk) disable iff (rst)
        up && tx_byte.valid |-> $past(txf) && $past(packet_mode))
        else $error("byte valid outside a packet clock fall");
    a_ins_sample: assert property (@(posedge ref_clk) disable iff (rst)
        up && !packet_mode && txf
        |=> tx_oh_bit.valid && tx_oh_bit.external == $past(ti_q[1] && tx_bit_insertable))
        else $error("insertion decision wrong at clock fall");
    a_ins_value: assert property (@(posedge ref_clk) disable iff (rst)
        up && tx_oh_bit.external |-> tx_oh_bit.bit_val == $past(td_q[1]))
        else $error("inserted bit value not taken from the pin");
endmodule
`default_nettype wire

// ### testbench/ohm_far_model.sv
// Purpose: Terminal equipment at the overhead / packet byte pins.
// Assumes: Link clocks run at 400 ns only while enabled, else stand low.
// Notes:   Next byte is offered once the current one has been latched.
`timescale 1ns/1ps
`default_nettype none
module ohm_far_model
(
    input  wire logic       rx_run,
    input  wire logic       tx_run,
    input  wire logic       ins_on,
    input  wire logic       ins_bit,
    input  wire logic       packet_mode,
    input  wire logic       tx_overhead_frame_pulse,
    output var  logic       rx_overhead_clock,
    output var  logic       tx_overhead_clock,
    output logic            tx_overhead_in,
    output logic            tx_overhead_insert,
    output var  logic [7:0] tx_packet_byte_bus
);
    initial
    begin
        rx_overhead_clock  = 1'h0;
        tx_overhead_clock  = 1'h0;
        tx_packet_byte_bus = 8'h5a;
    end
    // Clocks stand still low between frames, never parked high
    always
    begin
        #200;
        rx_overhead_clock = rx_run ? ~rx_overhead_clock : 1'h0;
        tx_overhead_clock = tx_run ? ~tx_overhead_clock : 1'h0;
    end
    // Data pin shows the inverse when not inserting, so stale bits never match
    assign tx_overhead_insert = ins_on;
    assign tx_overhead_in     = ins_on ? ins_bit : ~ins_bit;
    // Advance after the latch; bus stays put across the next fall
    always @(negedge tx_overhead_frame_pulse)
    begin
        if (packet_mode)
            tx_packet_byte_bus <= tx_packet_byte_bus + 8'h35;
    end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench of the overhead / packet byte pin mux.
// Assumes: ref_clk 50 ns, link clocks 400 ns from the far model.
// Notes:   One task per scenario; expectations come from fixed tables, bit formulas or fixed byte steps.
`timescale 1ns/1ps
`default_nettype none
`include "ohm_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench;
    import ohm_pkg::*;
    logic ref_clk = 1'h0, rst = 1'h1, packet_mode = 1'h0, rx_oh_valid = 1'h0;
    logic rx_oh_bit = 1'h0, tx_first_oh_req = 1'h0, tx_bit_insertable = 1'h0;
    logic rx_run = 1'h0, tx_run = 1'h0, ins_on = 1'h0, ins_bit = 1'h0;
    logic [7:0] rx_packet_byte_bus = 8'h00;
    logic rx_oh_ready, rx_overhead_clock, tx_overhead_clock, tx_overhead_in;
    logic tx_overhead_insert, rx_overhead_out, tx_overhead_frame_pulse;
    logic [7:0] tx_packet_byte_bus, exp_byte;
    ohm_tx_bit_t  tx_oh_bit;
    ohm_tx_byte_t tx_byte;
    int fail_count = 0, checks_done = 0, cyc = 0;
    ohm_port ohm_port_i (.ref_clk(ref_clk), .rst(rst), .packet_mode(packet_mode),
        .rx_oh_valid(rx_oh_valid), .rx_oh_ready(rx_oh_ready), .rx_oh_bit(rx_oh_bit),
        .rx_packet_byte_bus(rx_packet_byte_bus), .tx_first_oh_req(tx_first_oh_req),
        .tx_bit_insertable(tx_bit_insertable), .rx_overhead_clock(rx_overhead_clock),
        .tx_overhead_clock(tx_overhead_clock), .tx_overhead_in(tx_overhead_in),
        .tx_overhead_insert(tx_overhead_insert), .tx_packet_byte_bus(tx_packet_byte_bus),
        .rx_overhead_out(rx_overhead_out), .tx_overhead_frame_pulse(tx_overhead_frame_pulse),
        .tx_oh_bit(tx_oh_bit), .tx_byte(tx_byte));
    ohm_far_model ohm_far_model_i (.rx_run(rx_run), .tx_run(tx_run), .ins_on(ins_on),
        .ins_bit(ins_bit), .packet_mode(packet_mode),
        .tx_overhead_frame_pulse(tx_overhead_frame_pulse),
        .rx_overhead_clock(rx_overhead_clock), .tx_overhead_clock(tx_overhead_clock),
        .tx_overhead_in(tx_overhead_in), .tx_overhead_insert(tx_overhead_insert),
        .tx_packet_byte_bus(tx_packet_byte_bus));
    initial forever #25 ref_clk = ~ref_clk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait for a one-cycle valid pulse
    task wait_valid(input logic is_byte);
        for (int k = 0; k < 24; k++)
        begin
            step(1);
            if ((is_byte ? tx_byte.valid : tx_oh_bit.valid) === 1'h1)
                return;
        end
        `CHK("valid_seen", 1'h1, 1'h0)
    endtask
    // Fill all 16 places and check refusal, then drain bit by bit on clock rises
    task t_rx_fifo;
        for (int i = 0; i < 16; i++)
        begin
            rx_oh_valid = 1'h1;
            rx_oh_bit   = i[0] ^ i[2];
            step(1);
        end
        rx_oh_valid = 1'h0;
        `CHK("ready_full", 1'h0, rx_oh_ready)
        rx_run = 1'h1;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge rx_overhead_clock);
            step(6);
            `CHK("rx_bit", i[0] ^ i[2], rx_overhead_out)
        end
        rx_run = 1'h0;
        `CHK("ready_drained", 1'h1, rx_oh_ready)
    endtask
    // Packet mode: the same pin carries byte bit 6
    task t_rx_packet;
        logic [7:0] v [3] = '{8'h40, 8'hbf, 8'h7f};
        packet_mode = 1'h1;
        foreach (v[i])
        begin
            rx_packet_byte_bus = v[i];
            step(2);
            `CHK("rx_pkt_bit", v[i][6], rx_overhead_out)
        end
        packet_mode = 1'h0;
        step(4);
    endtask
    // One request gives one pulse lasting one link period of 8 cycles
    task t_frame_pulse;
        int n;
        n = 0;
        tx_first_oh_req = 1'h1;
        step(1);
        tx_first_oh_req = 1'h0;
        tx_run = 1'h1;
        repeat (32)
        begin
            step(1);
            if (tx_overhead_frame_pulse === 1'h1)
                n++;
        end
        tx_run = 1'h0;
        `CHK("pulse_cycles", 8, n)
        step(10);
    endtask
    // Table {insertable, insert, bit, external, held bit}
    task t_insert;
        logic [4:0] t [4] = '{5'b11111, 5'b11010, 5'b01100, 5'b10100};
        foreach (t[i])
        begin
            {tx_bit_insertable, ins_on, ins_bit} = t[i][4:2];
            step(4);
            tx_run = 1'h1;
            wait_valid(1'h0);
            `CHK("ins_external", t[i][1], tx_oh_bit.external)
            `CHK("ins_bit_val", t[i][0], tx_oh_bit.bit_val)
            tx_run = 1'h0;
            step(12);
        end
    endtask
    // Packet mode: bytes latched against the demand clock, in order
    task t_packet_tx;
        packet_mode = 1'h1;
        exp_byte    = 8'h5a;
        step(4);
        tx_run = 1'h1;
        repeat (4)
        begin
            wait_valid(1'h1);
            `CHK("tx_byte", exp_byte, tx_byte.data)
            exp_byte = exp_byte + 8'h35;
        end
        tx_run = 1'h0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        step(4);
        rst = 1'h0;
        step(2);
        `CHK("ready_reset", 1'h1, rx_oh_ready)
        t_rx_fifo();
        t_rx_packet();
        t_frame_pulse();
        t_insert();
        t_packet_tx();
        tally_and_finish();
    end
endmodule
bind ohm_port ohm_port_props ohm_port_props_i (.ref_clk(ref_clk), .rst(rst),
    .packet_mode(packet_mode), .rx_packet_byte_bus(rx_packet_byte_bus),
    .tx_first_oh_req(tx_first_oh_req), .tx_bit_insertable(tx_bit_insertable),
    .rx_overhead_clock(rx_overhead_clock), .tx_overhead_clock(tx_overhead_clock),
    .tx_overhead_in(tx_overhead_in), .tx_overhead_insert(tx_overhead_insert),
    .tx_packet_byte_bus(tx_packet_byte_bus), .rx_overhead_out(rx_overhead_out),
    .tx_overhead_frame_pulse(tx_overhead_frame_pulse), .tx_oh_bit(tx_oh_bit),
    .tx_byte(tx_byte));
`default_nettype wire
